// ---- sbs_params.svh ----
// Purpose: constants of the boundary scan test access port
// Assumes: included by the package, by the port top and by the bench
// Notes:   instruction codes and chain length are local choices
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH

// ----------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------
`define SBS_IR_W 3
`define SBS_IR_EXTEST 3'h0
`define SBS_IR_IDCODE 3'h1
`define SBS_IR_SAMPLEZ 3'h2
`define SBS_IR_SAMPLE 3'h4
`define SBS_IR_BYPASS 3'h7
`define SBS_IR_CAP_PAT 2'h1

// ----------------------------------------------------------------
// data registers
// ----------------------------------------------------------------
`define SBS_ID_W 32
// arbitrary identification value, bit 0 set as the scan standard asks
`define SBS_IDCODE_VAL 32'h5A3C_0001
`define SBS_BSR_LEN 64
`define SBS_BSR_TRI_BIT 47
// cells kept for pin positions of larger parts, captured as zero
`define SBS_NC_MASK 64'hF000_0000_0000_0000
`define SBS_PRELOAD_RST 64'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SBS_TLR_TMS_EDGES 5

`endif

// ---- sbs_pkg.sv ----
// Purpose: types of the boundary scan test access port
// Assumes: sbs_params.svh holds the numbers
// Notes:   shared by the controller and the port top
`include "sbs_params.svh"

package sbs_pkg;

  // ----------------------------------------------------------------
  // controller states and data register choice
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SELDR, ST_CAPDR, ST_SHDR, ST_EX1DR, ST_PADR, ST_EX2DR,
    ST_UPDR, ST_SELIR, ST_CAPIR, ST_SHIR, ST_EX1IR, ST_PAIR, ST_EX2IR, ST_UPIR
  } sbs_state_t;

  typedef enum logic [1:0] {SEL_BYP, SEL_ID, SEL_BSR} sbs_dsel_t;

  typedef logic [`SBS_IR_W-1:0] sbs_ir_t;

  // reserved codes fall back to the bypass cell so they stay harmless
  function automatic sbs_dsel_t sbs_dsel(input sbs_ir_t ir);
    case (ir)
      `SBS_IR_IDCODE: sbs_dsel = SEL_ID;
      `SBS_IR_EXTEST,
      `SBS_IR_SAMPLEZ,
      `SBS_IR_SAMPLE: sbs_dsel = SEL_BSR;
      default: sbs_dsel = SEL_BYP;
    endcase
  endfunction

endpackage

// ---- sbs_tap_fsm.sv ----
// Purpose: sixteen-state test access port controller
// Assumes: runs on the test clock, reset is synchronous and active high
// Notes:   advances on every rising test clock edge from the mode select
`timescale 1ns/10ps

module sbs_tap_fsm
  import sbs_pkg::*;
(
  // test clock side
  input wire logic tck_i,
  input wire logic rst_i,
  input wire logic tms_i,
  // state
  output sbs_state_t state_o
);

  sbs_state_t state;
  sbs_state_t next_state;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    case (state)
      ST_TLR: next_state = tms_i ? ST_TLR : ST_RTI;
      ST_RTI: next_state = tms_i ? ST_SELDR : ST_RTI;
      ST_SELDR: next_state = tms_i ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: next_state = tms_i ? ST_EX1DR : ST_SHDR;
      ST_SHDR: next_state = tms_i ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: next_state = tms_i ? ST_UPDR : ST_PADR;
      ST_PADR: next_state = tms_i ? ST_EX2DR : ST_PADR;
      ST_EX2DR: next_state = tms_i ? ST_UPDR : ST_SHDR;
      ST_UPDR: next_state = tms_i ? ST_SELDR : ST_RTI;
      ST_SELIR: next_state = tms_i ? ST_TLR : ST_CAPIR;
      ST_CAPIR: next_state = tms_i ? ST_EX1IR : ST_SHIR;
      ST_SHIR: next_state = tms_i ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: next_state = tms_i ? ST_UPIR : ST_PAIR;
      ST_PAIR: next_state = tms_i ? ST_EX2IR : ST_PAIR;
      ST_EX2IR: next_state = tms_i ? ST_UPIR : ST_SHIR;
      ST_UPIR: next_state = tms_i ? ST_SELDR : ST_RTI;
      default: next_state = ST_TLR;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge tck_i) begin
    if (rst_i) begin
      state <= ST_TLR;
    end else begin
      state <= next_state;
    end
  end

  assign state_o = state;

endmodule

// ---- sbs_tap.sv ----
// Behaviour
// - inputs sampled on rising test clock, serial output changes on falling edge
// - mode select sampled on rising edge; pad pull-up makes it high when open
// - serial input enters the top bit of the selected register
// - serial output comes from the bottom bit of the selected register
// - serial output driven only while shifting, otherwise released
// - five rising edges with mode select high reset the test logic only
// - test logic resets itself at power up with serial output released
// - the instruction selects exactly one register between input and output
// - instruction register is three bits, loaded serially while selected
// - identification instruction after power up and in test-logic reset
// - capture of instruction register loads 01 into its two low bits
// - bypass is one cell giving a single stage of delay
// - bypass cell is cleared to zero when bypass runs
// - boundary chain captures the pin ring, then shifts
// - boundary chain holds cells for unconnected pin positions
// - identification instruction captures a fixed 32-bit code, then shifts it
// - a shifted instruction takes effect only at the instruction update
//
// Purpose: boundary scan test access port of a burst memory
// Assumes: PIN_RING_I is on CLK_I; TCK_I is a separate, possibly stopped clock
// Notes:   pin snapshots cross by a two-phase toggle handshake, control levels by two flops
`timescale 1ns/10ps
`include "sbs_params.svh"

module sbs_tap
  import sbs_pkg::*;
#(
  parameter int BSR_LEN = `SBS_BSR_LEN,
  parameter logic [`SBS_ID_W-1:0] IDCODE = `SBS_IDCODE_VAL,
  parameter logic [`SBS_BSR_LEN-1:0] NC_MASK = `SBS_NC_MASK
)
(
  // system clock side
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic [BSR_LEN-1:0] PIN_RING_I,
  // test port
  input wire logic TCK_I,
  input wire logic TMS_I,
  input wire logic TDI_I,
  output logic TDO_O,
  output logic TDO_OE_O,
  // test control towards the memory pins
  output logic [BSR_LEN-1:0] PRELOAD_O,
  output logic EXTEST_O,
  output logic Q_OFF_O
);

  // ----------------------------------------------------------------
  // power-up reset into the test clock domain
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;
  logic tap_rst;

  always_ff @(posedge TCK_I) begin
    rst_meta <= RSTN_I;
    rst_sync <= rst_meta;
  end

  assign tap_rst = ~rst_sync;

  // ----------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------
  sbs_state_t state;

  sbs_tap_fsm u_fsm (
    .tck_i(TCK_I),
    .rst_i(tap_rst),
    .tms_i(TMS_I),
    .state_o(state)
  );

  // ----------------------------------------------------------------
  // test clock registers
  // ----------------------------------------------------------------
  sbs_ir_t ir;
  sbs_ir_t ir_sh;
  logic byp;
  logic [`SBS_ID_W-1:0] id_sh;
  logic [BSR_LEN-1:0] bsr_sh;
  logic [BSR_LEN-1:0] preload;
  logic [BSR_LEN-1:0] shadow;
  logic ack;
  logic rq_meta;
  logic rq_sync;
  logic drv_ext;
  logic drv_qoff;
  sbs_dsel_t dsel;
  logic [BSR_LEN-1:0] snap;
  logic req;

  sbs_ir_t next_ir;
  sbs_ir_t next_ir_sh;
  logic next_byp;
  logic [`SBS_ID_W-1:0] next_id_sh;
  logic [BSR_LEN-1:0] next_bsr_sh;
  logic [BSR_LEN-1:0] next_preload;
  logic [BSR_LEN-1:0] next_shadow;
  logic next_ack;
  logic next_drv_ext;
  logic next_drv_qoff;

  // the active instruction alone picks the data register
  assign dsel = sbs_dsel(ir);

  always_ff @(posedge TCK_I) begin
    rq_meta <= req;
    rq_sync <= rq_meta;
  end

  always_comb begin
    next_ir = ir;
    next_ir_sh = ir_sh;
    next_byp = byp;
    next_id_sh = id_sh;
    next_bsr_sh = bsr_sh;
    next_preload = preload;
    next_shadow = shadow;
    next_ack = ack;
    // a fresh pin snapshot is stable while the request is unanswered
    if (rq_sync != ack) begin
      next_shadow = snap;
      next_ack = rq_sync;
    end
    case (state)
      ST_CAPIR: begin
        next_ir_sh = {ir[`SBS_IR_W-1], `SBS_IR_CAP_PAT};
      end
      ST_SHIR: begin
        next_ir_sh = {TDI_I, ir_sh[`SBS_IR_W-1:1]};
      end
      ST_UPIR: begin
        next_ir = ir_sh;
      end
      ST_CAPDR: begin
        case (dsel)
          SEL_ID: next_id_sh = IDCODE;
          SEL_BSR: next_bsr_sh = shadow & ~NC_MASK;
          default: next_byp = 1'b0;
        endcase
      end
      ST_SHDR: begin
        case (dsel)
          SEL_ID: next_id_sh = {TDI_I, id_sh[`SBS_ID_W-1:1]};
          SEL_BSR: next_bsr_sh = {TDI_I, bsr_sh[BSR_LEN-1:1]};
          default: next_byp = TDI_I;
        endcase
      end
      ST_UPDR: begin
        if (dsel == SEL_BSR) begin
          next_preload = bsr_sh;
        end
      end
      default: begin
        next_ir = ir;
      end
    endcase
    // clear on the very edge that enters reset, as the test clock may stop right there
    if ((state == ST_TLR) || ((state == ST_SELIR) && TMS_I)) begin
      next_ir = `SBS_IR_IDCODE;
      next_preload = `SBS_PRELOAD_RST;
    end
    // sample-z floats the read bus; extest lets the preloaded cell decide
    next_drv_ext = (next_ir == `SBS_IR_EXTEST);
    next_drv_qoff = (next_ir == `SBS_IR_SAMPLEZ) ||
                    (next_drv_ext && !next_preload[`SBS_BSR_TRI_BIT]);
  end

  always_ff @(posedge TCK_I) begin
    if (tap_rst) begin
      ir <= `SBS_IR_IDCODE;
      ir_sh <= `SBS_IR_IDCODE;
      byp <= 1'b0;
      id_sh <= IDCODE;
      bsr_sh <= `SBS_PRELOAD_RST;
      preload <= `SBS_PRELOAD_RST;
      shadow <= `SBS_PRELOAD_RST;
      ack <= 1'b0;
      drv_ext <= 1'b0;
      drv_qoff <= 1'b0;
    end else begin
      ir <= next_ir;
      ir_sh <= next_ir_sh;
      byp <= next_byp;
      id_sh <= next_id_sh;
      bsr_sh <= next_bsr_sh;
      preload <= next_preload;
      shadow <= next_shadow;
      ack <= next_ack;
      drv_ext <= next_drv_ext;
      drv_qoff <= next_drv_qoff;
    end
  end

  assign PRELOAD_O = preload;

  // ----------------------------------------------------------------
  // serial output on the falling edge
  // ----------------------------------------------------------------
  logic tdo;
  logic tdo_oe;
  logic sel_lsb;
  logic next_tdo;
  logic next_tdo_oe;

  always_comb begin
    case (dsel)
      SEL_ID: sel_lsb = id_sh[0];
      SEL_BSR: sel_lsb = bsr_sh[0];
      default: sel_lsb = byp;
    endcase
    next_tdo_oe = (state == ST_SHIR) || (state == ST_SHDR);
    next_tdo = (state == ST_SHIR) ? ir_sh[0] : sel_lsb;
  end

  // half a test clock of hold for the next device in the chain
  always_ff @(negedge TCK_I) begin
    if (tap_rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= next_tdo;
      tdo_oe <= next_tdo_oe;
    end
  end

  assign TDO_O = tdo;
  assign TDO_OE_O = tdo_oe;

  // ----------------------------------------------------------------
  // system clock side: pin snapshot and control levels
  // ----------------------------------------------------------------
  logic ak_meta;
  logic ak_sync;
  logic ex_meta;
  logic ex_sync;
  logic qo_meta;
  logic qo_sync;
  logic [BSR_LEN-1:0] next_snap;
  logic next_req;

  always_comb begin
    next_snap = snap;
    next_req = req;
    // a stopped test clock simply freezes the last snapshot
    if (req == ak_sync) begin
      next_snap = PIN_RING_I;
      next_req = ~req;
    end
  end

  // the memory side never sees the test reset, so operation is not disturbed
  always_ff @(posedge CLK_I) begin
    ak_meta <= ack;
    ak_sync <= ak_meta;
    ex_meta <= drv_ext;
    qo_meta <= drv_qoff;
    if (!RSTN_I) begin
      snap <= `SBS_PRELOAD_RST;
      req <= 1'b0;
      ex_sync <= 1'b0;
      qo_sync <= 1'b0;
    end else begin
      snap <= next_snap;
      req <= next_req;
      ex_sync <= ex_meta;
      qo_sync <= qo_meta;
    end
  end

  assign EXTEST_O = ex_sync;
  assign Q_OFF_O = qo_sync;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  tms_reset_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    TMS_I [*5] |=> (state == ST_TLR) && (ir == `SBS_IR_IDCODE))
    else $error("five high mode select edges did not reset the port");

  ir_reset_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    (state == ST_TLR) |=> (ir == `SBS_IR_IDCODE))
    else $error("instruction is not identification after reset state");

  ir_capture_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    (state == ST_CAPIR) |=> (ir_sh[1:0] == 2'h1))
    else $error("instruction capture did not load 01");

  ir_shift_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    (state == ST_SHIR) |=> (ir_sh[2] == $past(TDI_I)) && (ir_sh[1:0] == $past(ir_sh[2:1])))
    else $error("instruction register did not shift from the top");

  ir_hold_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    (state != ST_UPIR) && (state != ST_TLR) && !((state == ST_SELIR) && TMS_I) |=> $stable(ir))
    else $error("instruction changed outside update");

  ir_update_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    (state == ST_UPIR) |=> (ir == $past(ir_sh)))
    else $error("instruction update did not take the shifted value");

  tdo_enable_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    ##1 (tdo_oe == (($past(state) != ST_TLR) && ((state == ST_SHIR) || (state == ST_SHDR)))
         || ($past(state) == ST_TLR) && (tdo_oe == (state == ST_SHDR || state == ST_SHIR))))
    else $error("serial output enable outside shift states");

  tdo_lsb_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    (state == ST_SHDR) && (dsel == SEL_BYP) ##1 (state == ST_SHDR) |-> (tdo == byp))
    else $error("serial output is not the bypass cell");

  bypass_clear_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    (state == ST_CAPDR) && (dsel == SEL_BYP) |=> (byp == 1'b0))
    else $error("bypass cell not cleared on capture");

  bypass_delay_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    (state == ST_SHDR) && (dsel == SEL_BYP) |=> (byp == $past(TDI_I)))
    else $error("bypass is not a single stage");

  id_capture_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    (state == ST_CAPDR) && (ir == `SBS_IR_IDCODE) |=> (id_sh == IDCODE))
    else $error("identification code not captured");

  reserved_bypass_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    (ir == 3'h3) || (ir == 3'h5) || (ir == 3'h6) |-> (dsel == SEL_BYP) && !drv_ext && !drv_qoff)
    else $error("reserved instruction not routed to bypass");

  nc_cells_a: assert property (
    @(posedge TCK_I) disable iff (tap_rst)
    (state == ST_CAPDR) && (dsel == SEL_BSR) |=> ((bsr_sh & NC_MASK) == '0))
    else $error("unconnected cells did not capture zero");

endmodule

// ---- sbs_jtag_model.sv ----
// Purpose: behavioural board test controller driving the scan port
// Assumes: the bench calls cyc once for each test clock period
// Notes:   test clock stands low between calls
`timescale 1ns/10ps

module sbs_jtag_model (
  // test port towards the device
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  // serial answer
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  logic last = 1'b0;
  logic lvl;

  // a released output has no pull, so it reads as the inverse of its last level
  assign lvl = tdo_oe_i ? tdo_i : ~last;

  always @(posedge tck_o) begin
    if (tdo_oe_i) begin
      last <= tdo_i;
    end
  end

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // one period: inputs set while low, answer read just before the rise
  task automatic cyc(input logic ms, input logic di, output logic q, output logic oe);
    tms_o = ms;
    tdi_o = di;
    #62.5;
    q = lvl;
    oe = tdo_oe_i;
    tck_o = 1'b1;
    #62.5;
    tck_o = 1'b0;
  endtask
endmodule

// ---- sbs_tb.sv ----
// Purpose: self-checking bench of the boundary scan port
// Assumes: sbs_jtag_model makes the test clock at 125 ns
// Notes:   reset is held until the test clock has given four rises
`timescale 1ns/10ps
`include "sbs_params.svh"

module testbench
  import sbs_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [63:0] pins = '0;
  logic tck, tms, tdi, tdo, tdo_oe, extest, q_off;
  logic [63:0] preload;
  logic q, oe, a, b;
  logic [63:0] d;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  sbs_tap uut (.CLK_I(clk), .RSTN_I(rstn), .PIN_RING_I(pins), .TCK_I(tck), .TMS_I(tms),
    .TDI_I(tdi), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .PRELOAD_O(preload), .EXTEST_O(extest),
    .Q_OFF_O(q_off));

  sbs_jtag_model ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  // ----------------------------------------------------------------
  // compare and closing
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a hung handshake would otherwise stall the run forever
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      stop_test;
    end
  end

  // ----------------------------------------------------------------
  // scan helpers; scan starts from run-test-idle, go from any state
  // ----------------------------------------------------------------
  task automatic go(input int n, input logic [15:0] ms);
    for (int i = 0; i < n; i++) begin
      ctl.cyc(ms[i], 1'b0, q, oe);
    end
  endtask

  task automatic scan(input bit ir, input int n, input logic [63:0] din, output logic [63:0] dout,
                      output logic oe_in, output logic oe_out);
    dout = '0;
    ctl.cyc(1'b1, 1'b1, q, oe);
    if (ir) begin
      ctl.cyc(1'b1, 1'b1, q, oe);
    end
    go(2, 16'h0);
    for (int i = 0; i < n; i++) begin
      ctl.cyc(i == n - 1, din[i], q, oe);
      dout[i] = q;
      if (i == 0) begin
        oe_in = oe;
      end
    end
    ctl.cyc(1'b1, 1'b1, q, oe);
    oe_out = oe;
    ctl.cyc(1'b0, 1'b1, q, oe);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_idcode;
    ctl.cyc(1'b0, 1'b1, q, oe);
    chk_bit(oe, 1'b0);
    scan(0, 32, '1, d, a, b);
    chk_val(d, 64'(`SBS_IDCODE_VAL));
    chk_bit(a, 1'b1);
    chk_bit(b, 1'b0);
  endtask

  // bypass and every reserved code give one cell that captures zero
  task automatic t_bypass;
    logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
    logic [2:0] prev;
    prev = `SBS_IR_IDCODE;
    foreach (codes[k]) begin
      scan(1, 3, 64'(codes[k]), d, a, b);
      chk_val(d, 64'({prev[2], `SBS_IR_CAP_PAT}));
      prev = codes[k];
      scan(0, 8, 64'hA5, d, a, b);
      chk_val(d, 64'h4A);
    end
  endtask

  task automatic t_boundary;
    scan(1, 3, 64'(`SBS_IR_SAMPLE), d, a, b);
    chk_val(d, 64'h5);
    @(negedge clk);
    pins = 64'hFEDC_BA98_7654_3210;
    // the pin snapshot needs a running test clock to cross
    go(10, 16'h0);
    scan(0, 64, 64'h1234_8000_0000_00C3, d, a, b);
    chk_val(d, 64'hFEDC_BA98_7654_3210 & ~`SBS_NC_MASK);
    chk_val(preload, 64'h1234_8000_0000_00C3);
  endtask

  task automatic t_update;
    go(9, 16'h0043);
    repeat (10) @(negedge clk);
    chk_bit(extest, 1'b0);
    go(3, 16'h0003);
    repeat (4) @(negedge clk);
    chk_bit(extest, 1'b1);
    chk_bit(q_off, 1'b0);
  endtask

  // test reset from the middle of a data shift
  task automatic t_tms_reset;
    go(3, 16'h0001);
    go(5, 16'h001F);
    repeat (4) @(negedge clk);
    chk_bit(extest, 1'b0);
    chk_val(preload, 64'h0);
    t_idcode;
    scan(1, 3, 64'(`SBS_IR_SAMPLEZ), d, a, b);
    chk_val(d, 64'h1);
    repeat (4) @(negedge clk);
    chk_bit(q_off, 1'b1);
    // extest after a test reset: the cleared preload floats the read bus
    scan(1, 3, 64'(`SBS_IR_EXTEST), d, a, b);
    chk_val(d, 64'h1);
    repeat (4) @(negedge clk);
    chk_bit(extest, 1'b1);
    chk_bit(q_off, 1'b1);
  endtask

  initial begin
    repeat (6) @(negedge clk);
    repeat (4) ctl.cyc(1'b1, 1'b1, q, oe);
    @(negedge clk);
    rstn = 1'b1;
    repeat (3) ctl.cyc(1'b1, 1'b1, q, oe);
    t_idcode;
    t_bypass;
    t_boundary;
    t_update;
    t_tms_reset;
    stop_test;
  end
endmodule
